// ===== core/doc_bus.sv
/*
  one output bus driver: number format, flag and three-state enable, all
  registered so the pins come straight from flip-flops.
  assumes the caller has already chosen which channel feeds this bus.
*/
`timescale 1ns/1ns
module doc_bus (
  input wire logic clock,
  input wire logic rst,
  input wire logic [doc_pkg::WORD_W-1:0] word_in,
  input wire logic flag_in,
  input wire logic twos,
  input wire logic drive,
  output logic [doc_pkg::WORD_W-1:0] bus,
  output logic flag,
  output logic bus_oe_n
);

  typedef struct packed {
    logic [doc_pkg::WORD_W-1:0] bus;
    logic flag;
    logic oe_n;
  } doc_bus_s;

  doc_bus_s st;
  doc_bus_s next_st;

  // two's complement is offset binary with the top bit turned over
  always_comb begin
    next_st = st;
    next_st.bus = word_in;
    next_st.bus[doc_pkg::MSB_POS] = word_in[doc_pkg::MSB_POS] ^ twos;
    next_st.flag = flag_in;
    next_st.oe_n = ~drive;
  end

  // pins start released so nothing fights the bus during reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '{bus: '0, flag: 1'b0, oe_n: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign bus = st.bus;
  assign flag = st.flag;
  assign bus_oe_n = st.oe_n;

endmodule

// ===== core/doc_pipe.sv
/*
  one converter channel pipeline: takes a word on each qualified sample edge
  and hands it out after the documented number of sample edges.
  assumes the sample edge is a one-cycle pulse in the system clock domain.
*/
`timescale 1ns/1ns
module doc_pipe (
  input wire logic clock,
  input wire logic rst,
  input wire logic sample_edge,
  input wire logic run,
  input wire logic [doc_pkg::WORD_W-1:0] code_in,
  input wire logic range_in,
  output logic [doc_pkg::WORD_W-1:0] word_out,
  output logic flag_out,
  output logic word_valid
);

  typedef struct packed {
    logic [doc_pkg::LATENCY-1:0][doc_pkg::WORD_W:0] stage;
    logic [doc_pkg::WORD_W:0] out;
    logic [doc_pkg::FILL_W-1:0] fill;
    logic valid;
  } doc_pipe_s;

  doc_pipe_s st;
  doc_pipe_s next_st;

  // shift on each edge while converting; a parked channel keeps its contents
  always_comb begin
    next_st = st;
    next_st.valid = 1'b0;
    if (sample_edge && run) begin
      next_st.stage[0] = {range_in, code_in};
      for (int i = 1; i < doc_pkg::LATENCY; i++) begin
        next_st.stage[i] = st.stage[i-1];
      end
      next_st.out = st.stage[doc_pkg::LATENCY-1];
      // only words that really went through every stage count as results
      next_st.valid = (st.fill == doc_pkg::FILL_FULL);
      if (st.fill != doc_pkg::FILL_FULL) begin
        next_st.fill = st.fill + 3'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign word_out = st.out[doc_pkg::WORD_W-1:0];
  assign flag_out = st.out[doc_pkg::WORD_W];
  assign word_valid = st.valid;

endmodule

// ===== core/doc_pkg.sv
/*
  shared constants and types for the dual converter output control block:
  register offsets and fields, reset values, pipeline depth, mode encodings.
  assumes a 32-bit apb slave with an 8-bit byte address and one clock.
*/
package doc_pkg;

  // ****************************************
  // converter data path
  // ****************************************
  localparam int WORD_W = 10;
  localparam int LATENCY = 5;
  localparam int FILL_W = 3;
  localparam logic [FILL_W-1:0] FILL_FULL = 3'h5;
  localparam int MSB_POS = 9;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam logic [7:0] OFS_LAST_A = 8'h10;
  localparam logic [7:0] OFS_LAST_B = 8'h14;
  localparam logic [7:0] OFS_COUNT_A = 8'h18;
  localparam logic [7:0] OFS_COUNT_B = 8'h1c;

  // control fields and reset value
  localparam int CTRL_SNAP_POS = 0;
  localparam logic [31:0] CONTROL_RESET = 32'h00000001;
  localparam logic [31:0] CONTROL_MASK = 32'h00000001;

  // interrupt fields
  localparam int IRQ_W = 4;
  localparam int IRQ_WORD_A_POS = 0;
  localparam int IRQ_WORD_B_POS = 1;
  localparam int IRQ_RANGE_A_POS = 2;
  localparam int IRQ_RANGE_B_POS = 3;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

  // capture and counter widths
  localparam int LAST_W = 11;
  localparam int COUNT_W = 16;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;

  // ****************************************
  // modes
  // ****************************************
  typedef enum logic [1:0] {POWER_NORMAL, POWER_HIZ, POWER_NAP, POWER_SLEEP} doc_power_e;
  typedef enum logic [1:0] {LEVEL_GND, LEVEL_THIRD, LEVEL_TWO_THIRDS, LEVEL_SUPPLY} doc_level_e;

endpackage

// ===== core/doc_top.sv
/*
  dual converter output control: sample edge detection, per-channel power
  modes, pipelines, bus swap, format and stabilizer choice, apb registers
  and a level interrupt.
  assumes all pin inputs are synchronous to CLOCK, the four-level mode pin
  arrives already encoded as two bits, and analog results arrive as a code
  and a range flag per channel.
*/
`timescale 1ns/1ns

module doc_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic SAMPLE_CLOCK_CHAN_A,
  input wire logic SAMPLE_CLOCK_CHAN_B,
  input wire logic [doc_pkg::WORD_W-1:0] ANALOG_CODE_CHAN_A,
  input wire logic ANALOG_RANGE_CHAN_A,
  input wire logic [doc_pkg::WORD_W-1:0] ANALOG_CODE_CHAN_B,
  input wire logic ANALOG_RANGE_CHAN_B,
  input wire logic OUTPUT_SWAP_SELECT,
  input wire logic POWER_DOWN_CHAN_A,
  input wire logic POWER_DOWN_CHAN_B,
  input wire logic OUTPUT_ENABLE_N_CHAN_A,
  input wire logic OUTPUT_ENABLE_N_CHAN_B,
  input wire logic [1:0] MODE_LEVEL,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [doc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic [doc_pkg::WORD_W-1:0] RESULT_BUS_A,
  output logic RANGE_FLAG_BUS_A,
  output logic RESULT_BUS_A_OE_N,
  output logic [doc_pkg::WORD_W-1:0] RESULT_BUS_B,
  output logic RANGE_FLAG_BUS_B,
  output logic RESULT_BUS_B_OE_N,
  output logic DUTY_STABILIZER_ON
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic clk_a_q;
    logic clk_b_q;
    doc_pkg::doc_power_e power_a;
    doc_pkg::doc_power_e power_b;
    logic twos;
    logic stabilizer;
    logic [31:0] control;
    logic [doc_pkg::IRQ_W-1:0] irq_status;
    logic [doc_pkg::IRQ_W-1:0] irq_mask;
    logic [doc_pkg::LAST_W-1:0] last_a;
    logic [doc_pkg::LAST_W-1:0] last_b;
    logic [doc_pkg::COUNT_W-1:0] count_a;
    logic [doc_pkg::COUNT_W-1:0] count_b;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } doc_top_s;

  doc_top_s st;
  doc_top_s next_st;

  logic edge_a;
  logic edge_b;
  logic run_a;
  logic run_b;
  logic drive_a;
  logic drive_b;
  doc_pkg::doc_power_e mode_a;
  doc_pkg::doc_power_e mode_b;
  doc_pkg::doc_level_e level;
  logic twos_now;
  logic stab_now;
  logic [doc_pkg::WORD_W-1:0] word_a;
  logic [doc_pkg::WORD_W-1:0] word_b;
  logic flag_a;
  logic flag_b;
  logic valid_a;
  logic valid_b;
  logic [doc_pkg::WORD_W-1:0] sel_word_a;
  logic [doc_pkg::WORD_W-1:0] sel_word_b;
  logic sel_flag_a;
  logic sel_flag_b;
  logic sel_drive_a;
  logic sel_drive_b;
  logic [doc_pkg::WORD_W-1:0] fmt_a;
  logic [doc_pkg::WORD_W-1:0] fmt_b;

  // ****************************************
  // sample edges and power modes
  // ****************************************

  // the channel clocks are independent, so each gets its own edge detector
  assign edge_a = SAMPLE_CLOCK_CHAN_A & ~st.clk_a_q;
  assign edge_b = SAMPLE_CLOCK_CHAN_B & ~st.clk_b_q;

  // four pin combinations per channel, one mode each
  always_comb begin
    unique case ({POWER_DOWN_CHAN_A, OUTPUT_ENABLE_N_CHAN_A})
      2'b00: mode_a = doc_pkg::POWER_NORMAL;
      2'b01: mode_a = doc_pkg::POWER_HIZ;
      2'b10: mode_a = doc_pkg::POWER_NAP;
      2'b11: mode_a = doc_pkg::POWER_SLEEP;
    endcase
    unique case ({POWER_DOWN_CHAN_B, OUTPUT_ENABLE_N_CHAN_B})
      2'b00: mode_b = doc_pkg::POWER_NORMAL;
      2'b01: mode_b = doc_pkg::POWER_HIZ;
      2'b10: mode_b = doc_pkg::POWER_NAP;
      2'b11: mode_b = doc_pkg::POWER_SLEEP;
    endcase
  end

  // a channel converts whenever it is not shut down; it drives only in normal
  assign run_a = ~POWER_DOWN_CHAN_A;
  assign run_b = ~POWER_DOWN_CHAN_B;
  assign drive_a = (mode_a == doc_pkg::POWER_NORMAL);
  assign drive_b = (mode_b == doc_pkg::POWER_NORMAL);

  // ****************************************
  // shared mode level
  // ****************************************

  // one pin sets format and stabilizer for both channels at once
  always_comb begin
    level = doc_pkg::doc_level_e'(MODE_LEVEL);
    unique case (level)
      doc_pkg::LEVEL_GND: begin
        twos_now = 1'b0;
        stab_now = 1'b0;
      end
      doc_pkg::LEVEL_THIRD: begin
        twos_now = 1'b0;
        stab_now = 1'b1;
      end
      doc_pkg::LEVEL_TWO_THIRDS: begin
        twos_now = 1'b1;
        stab_now = 1'b1;
      end
      doc_pkg::LEVEL_SUPPLY: begin
        twos_now = 1'b1;
        stab_now = 1'b0;
      end
    endcase
  end

  // ****************************************
  // channel pipelines
  // ****************************************
  doc_pipe pipe_a (
    .clock(CLOCK),
    .rst(RST),
    .sample_edge(edge_a),
    .run(run_a),
    .code_in(ANALOG_CODE_CHAN_A),
    .range_in(ANALOG_RANGE_CHAN_A),
    .word_out(word_a),
    .flag_out(flag_a),
    .word_valid(valid_a)
  );

  doc_pipe pipe_b (
    .clock(CLOCK),
    .rst(RST),
    .sample_edge(edge_b),
    .run(run_b),
    .code_in(ANALOG_CODE_CHAN_B),
    .range_in(ANALOG_RANGE_CHAN_B),
    .word_out(word_b),
    .flag_out(flag_b),
    .word_valid(valid_b)
  );

  // ****************************************
  // bus swap
  // ****************************************

  // the enable travels with the channel, so a released channel stays released
  // on whichever bus it lands; tying the swap pin to both sample clocks
  // interleaves the two channels on one bus, which is only sound up to 80Msps
  assign sel_word_a = OUTPUT_SWAP_SELECT ? word_a : word_b;
  assign sel_flag_a = OUTPUT_SWAP_SELECT ? flag_a : flag_b;
  assign sel_drive_a = OUTPUT_SWAP_SELECT ? drive_a : drive_b;
  assign sel_word_b = OUTPUT_SWAP_SELECT ? word_b : word_a;
  assign sel_flag_b = OUTPUT_SWAP_SELECT ? flag_b : flag_a;
  assign sel_drive_b = OUTPUT_SWAP_SELECT ? drive_b : drive_a;

  doc_bus bus_a (
    .clock(CLOCK),
    .rst(RST),
    .word_in(sel_word_a),
    .flag_in(sel_flag_a),
    .twos(twos_now),
    .drive(sel_drive_a),
    .bus(RESULT_BUS_A),
    .flag(RANGE_FLAG_BUS_A),
    .bus_oe_n(RESULT_BUS_A_OE_N)
  );

  doc_bus bus_b (
    .clock(CLOCK),
    .rst(RST),
    .word_in(sel_word_b),
    .flag_in(sel_flag_b),
    .twos(twos_now),
    .drive(sel_drive_b),
    .bus(RESULT_BUS_B),
    .flag(RANGE_FLAG_BUS_B),
    .bus_oe_n(RESULT_BUS_B_OE_N)
  );

  // captured words use the same format as the pins, per channel not per bus
  assign fmt_a = {word_a[doc_pkg::MSB_POS] ^ twos_now, word_a[doc_pkg::MSB_POS-1:0]};
  assign fmt_b = {word_b[doc_pkg::MSB_POS] ^ twos_now, word_b[doc_pkg::MSB_POS-1:0]};

  // ****************************************
  // registers, interrupt and apb slave
  // ****************************************
  always_comb begin
    logic [31:0] rd;
    logic hit;
    logic take;
    logic wr;
    logic [doc_pkg::IRQ_W-1:0] events;
    rd = 32'h00000000;
    hit = 1'b1;
    take = 1'b0;
    wr = 1'b0;
    events = '0;
    next_st = st;

    // pin history and registered views of the mode pins
    next_st.clk_a_q = SAMPLE_CLOCK_CHAN_A;
    next_st.clk_b_q = SAMPLE_CLOCK_CHAN_B;
    next_st.power_a = mode_a;
    next_st.power_b = mode_b;
    next_st.twos = twos_now;
    next_st.stabilizer = stab_now;

    // sample counters count accepted edges; they wrap rather than saturate
    if (edge_a && run_a) begin
      next_st.count_a = st.count_a + doc_pkg::COUNT_ONE;
    end
    if (edge_b && run_b) begin
      next_st.count_b = st.count_b + doc_pkg::COUNT_ONE;
    end

    // snapshot of the newest result, frozen while software clears the bit
    if (valid_a && st.control[doc_pkg::CTRL_SNAP_POS]) begin
      next_st.last_a = {flag_a, fmt_a};
    end
    if (valid_b && st.control[doc_pkg::CTRL_SNAP_POS]) begin
      next_st.last_b = {flag_b, fmt_b};
    end

    // events: a new result, and a result that was out of range
    events[doc_pkg::IRQ_WORD_A_POS] = valid_a;
    events[doc_pkg::IRQ_WORD_B_POS] = valid_b;
    events[doc_pkg::IRQ_RANGE_A_POS] = valid_a & flag_a;
    events[doc_pkg::IRQ_RANGE_B_POS] = valid_b & flag_b;

    // read decode; unmapped addresses read zero and report an error
    unique case (PADDR)
      doc_pkg::OFS_CONTROL: rd = st.control;
      doc_pkg::OFS_STATUS: rd = {23'h000000, OUTPUT_SWAP_SELECT, st.stabilizer, st.twos,
                                 MODE_LEVEL, st.power_b, st.power_a};
      doc_pkg::OFS_IRQ_STATUS: rd = {28'h0000000, st.irq_status};
      doc_pkg::OFS_IRQ_MASK: rd = {28'h0000000, st.irq_mask};
      doc_pkg::OFS_LAST_A: rd = {21'h000000, st.last_a};
      doc_pkg::OFS_LAST_B: rd = {21'h000000, st.last_b};
      doc_pkg::OFS_COUNT_A: rd = {16'h0000, st.count_a};
      doc_pkg::OFS_COUNT_B: rd = {16'h0000, st.count_b};
      default: hit = 1'b0;
    endcase

    // setup cycle loads the answer, so the access phase is always one cycle
    take = PSEL & ~PENABLE;
    next_st.pready = take;
    if (take) begin
      next_st.prdata = PWRITE ? 32'h00000000 : rd;
      next_st.pslverr = ~hit;
    end else begin
      next_st.pslverr = 1'b0;
    end

    // writes land at the edge that closes the access phase
    wr = PSEL & PENABLE & st.pready & PWRITE;
    next_st.irq_status = st.irq_status;
    if (wr && PADDR == doc_pkg::OFS_CONTROL) begin
      next_st.control = PWDATA & doc_pkg::CONTROL_MASK;
    end
    if (wr && PADDR == doc_pkg::OFS_IRQ_MASK) begin
      next_st.irq_mask = PWDATA[doc_pkg::IRQ_W-1:0];
    end
    if (wr && PADDR == doc_pkg::OFS_IRQ_STATUS) begin
      next_st.irq_status = st.irq_status & ~PWDATA[doc_pkg::IRQ_W-1:0];
    end
    // an event in the clearing cycle survives the clear
    next_st.irq_status = next_st.irq_status | events;

    // level interrupt follows the registered status in the same cycle
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);
  end

  // state register; pins that face the board start quiet
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st <= '{
        clk_a_q: 1'b0,
        clk_b_q: 1'b0,
        power_a: doc_pkg::POWER_NORMAL,
        power_b: doc_pkg::POWER_NORMAL,
        twos: 1'b0,
        stabilizer: 1'b0,
        control: doc_pkg::CONTROL_RESET,
        irq_status: doc_pkg::IRQ_STATUS_RESET,
        irq_mask: doc_pkg::IRQ_MASK_RESET,
        last_a: '0,
        last_b: '0,
        count_a: doc_pkg::COUNT_RESET,
        count_b: doc_pkg::COUNT_RESET,
        prdata: 32'h00000000,
        pready: 1'b0,
        pslverr: 1'b0,
        irq: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign IRQ = st.irq;
  assign DUTY_STABILIZER_ON = st.stabilizer;

endmodule

// ===== test/doc_capture.sv
/*
  capture model for one parallel result bus: works out the level of the wire.
  assumes an active low output enable and the system clock.
*/
`timescale 1ns/1ns
module doc_capture (
  input wire logic clock,
  input wire logic [9:0] bus,
  input wire logic flag,
  input wire logic oe_n,
  output logic [10:0] seen
);
  logic [10:0] last = 11'h000;
  // a released bus shows the inverse of the last driven word, so stale data never passes
  assign seen = oe_n ? ~last : {flag, bus};
  // remember the word last driven
  always @(posedge clock) begin
    if (!oe_n) begin
      last <= {flag, bus};
    end
  end
endmodule

// ===== test/doc_top_assertions.sv
/*
  pin checker for doc_top: bus enables, swap, format, hold and apb answer.
  assumes it is bound to doc_top, one clock, asynchronous high reset.
*/
`timescale 1ns/1ns
module doc_top_chk (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic SAMPLE_CLOCK_CHAN_A,
  input wire logic SAMPLE_CLOCK_CHAN_B,
  input wire logic OUTPUT_SWAP_SELECT,
  input wire logic POWER_DOWN_CHAN_A,
  input wire logic POWER_DOWN_CHAN_B,
  input wire logic OUTPUT_ENABLE_N_CHAN_A,
  input wire logic OUTPUT_ENABLE_N_CHAN_B,
  input wire logic [1:0] MODE_LEVEL,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic [doc_pkg::WORD_W-1:0] RESULT_BUS_A,
  input wire logic RESULT_BUS_A_OE_N,
  input wire logic RESULT_BUS_B_OE_N,
  input wire logic DUTY_STABILIZER_ON
);
  // ****************************************
  // sequences
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  // no sample edge and no swap change; the past reset is excluded so reset values are not compared
  // the bus register adds a stage, so an edge one cycle back is what moves the pins now
  sequence quiet;
    !$past(RST) && !($past(SAMPLE_CLOCK_CHAN_A) && !$past(SAMPLE_CLOCK_CHAN_A, 2))
      && !($past(SAMPLE_CLOCK_CHAN_B) && !$past(SAMPLE_CLOCK_CHAN_B, 2)) && $stable(OUTPUT_SWAP_SELECT);
  endsequence
  sequence setup;
    PSEL && !PENABLE;
  endsequence
  // ****************************************
  // properties
  // ****************************************
  AST_NORMAL_A: assert property (!RST && OUTPUT_SWAP_SELECT && !POWER_DOWN_CHAN_A && !OUTPUT_ENABLE_N_CHAN_A
    |=> !RESULT_BUS_A_OE_N) else $error("bus a not driven in normal mode");
  AST_CROSS_A: assert property (!OUTPUT_SWAP_SELECT && !POWER_DOWN_CHAN_B && !OUTPUT_ENABLE_N_CHAN_B
    |=> !RESULT_BUS_A_OE_N) else $error("bus a not driven by channel b");
  AST_HIZ_A: assert property (OUTPUT_SWAP_SELECT && OUTPUT_ENABLE_N_CHAN_A |=> RESULT_BUS_A_OE_N)
    else $error("bus a driven while enable is off");
  AST_NAP_A: assert property (OUTPUT_SWAP_SELECT && POWER_DOWN_CHAN_A |=> RESULT_BUS_A_OE_N)
    else $error("bus a driven in nap");
  AST_SLEEP_B: assert property (OUTPUT_SWAP_SELECT && POWER_DOWN_CHAN_B && OUTPUT_ENABLE_N_CHAN_B
    |=> RESULT_BUS_B_OE_N) else $error("bus b driven in sleep");
  AST_HOLD_A: assert property (quiet ##0 $stable(MODE_LEVEL) |=> $stable(RESULT_BUS_A))
    else $error("bus a changed without a sample edge");
  AST_FORMAT_A: assert property (quiet ##0 (MODE_LEVEL == 2'h2 && $past(MODE_LEVEL) == 2'h1)
    |=> RESULT_BUS_A == ($past(RESULT_BUS_A) ^ 10'h200)) else $error("format change not a top bit flip");
  AST_STAB: assert property (!$past(RST) |-> DUTY_STABILIZER_ON == ($past(MODE_LEVEL) inside {2'h1, 2'h2}))
    else $error("stabilizer does not follow mode");
  AST_APB_READY: assert property (setup |=> PREADY ##1 !PREADY)
    else $error("apb answer not one cycle after setup");
endmodule

bind doc_top doc_top_chk i_chk (.CLOCK, .RST, .SAMPLE_CLOCK_CHAN_A, .SAMPLE_CLOCK_CHAN_B, .OUTPUT_SWAP_SELECT,
  .POWER_DOWN_CHAN_A, .POWER_DOWN_CHAN_B, .OUTPUT_ENABLE_N_CHAN_A, .OUTPUT_ENABLE_N_CHAN_B, .MODE_LEVEL, .PSEL,
  .PENABLE, .PREADY, .RESULT_BUS_A, .RESULT_BUS_A_OE_N, .RESULT_BUS_B_OE_N, .DUTY_STABILIZER_ON);

// ===== test/doc_top_tb.sv
/*
  bench for doc_top: registers, pipeline delay, swap, format, power modes, irq.
  assumes one doc_capture per output bus resolves the wire.
*/
`timescale 1ns/1ns
module doc_top_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic sca = 1'b0, scb = 1'b0, ra = 1'b0, rb = 1'b0, swap = 1'b1;
  logic pda = 1'b0, pdb = 1'b0, output_enable_n_chan_a = 1'b0, output_enable_n_chan_b = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, irq, fa, fb, oe_a, oe_b, stab, err;
  logic [9:0] ca = 10'h000, cb = 10'h000, bus_a, bus_b;
  logic [1:0] mode = 2'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [10:0] seen_a, seen_b;
  logic [10:0] qa[$], qb[$];
  int fail_count = 0;
  int compares = 0;

  // ****************************************
  // clock, design and bus models
  // ****************************************
  always #5 clock = ~clock;
  doc_top i_dut (.CLOCK(clock), .RST(rst), .SAMPLE_CLOCK_CHAN_A(sca), .SAMPLE_CLOCK_CHAN_B(scb),
    .ANALOG_CODE_CHAN_A(ca), .ANALOG_RANGE_CHAN_A(ra), .ANALOG_CODE_CHAN_B(cb), .ANALOG_RANGE_CHAN_B(rb),
    .OUTPUT_SWAP_SELECT(swap), .POWER_DOWN_CHAN_A(pda), .POWER_DOWN_CHAN_B(pdb),
    .OUTPUT_ENABLE_N_CHAN_A(output_enable_n_chan_a), .OUTPUT_ENABLE_N_CHAN_B(output_enable_n_chan_b), .MODE_LEVEL(mode), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .RESULT_BUS_A(bus_a), .RANGE_FLAG_BUS_A(fa), .RESULT_BUS_A_OE_N(oe_a),
    .RESULT_BUS_B(bus_b), .RANGE_FLAG_BUS_B(fb), .RESULT_BUS_B_OE_N(oe_b), .DUTY_STABILIZER_ON(stab));
  doc_capture i_cap_a (.clock(clock), .bus(bus_a), .flag(fa), .oe_n(oe_a), .seen(seen_a));
  doc_capture i_cap_b (.clock(clock), .bus(bus_b), .flag(fb), .oe_n(oe_b), .seen(seen_b));

  // ****************************************
  // shared tasks
  // ****************************************
  // one comparison, counted; an unknown matches only an unknown
  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // expected word: the sample five accepted edges back, top bit flipped in two's complement
  function automatic logic [10:0] expw(input logic [10:0] q[$]);
    logic [10:0] w;
    w = (q.size() > doc_pkg::LATENCY) ? q[q.size() - 1 - doc_pkg::LATENCY] : 11'h000;
    return w ^ {1'b0, mode[1], 9'h000};
  endfunction
  // apb transfer: setup, then hold the access phase until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    pen <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (n >= 50) chk(11'h000, 11'h001, "apb no answer");
    #1;
  endtask
  // one sample clock period per channel asked for; accepted samples enter the model queues
  task automatic pulse(input logic ea, input logic eb, input logic [10:0] va, input logic [10:0] vb);
    @(posedge clock);
    sca <= ea;
    scb <= eb;
    {ra, ca} <= va;
    {rb, cb} <= vb;
    repeat (2) @(posedge clock);
    sca <= 1'b0;
    scb <= 1'b0;
    repeat (2) @(posedge clock);
    if (ea && !pda) qa.push_back(va);
    if (eb && !pdb) qb.push_back(vb);
    #1;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    apb(1'b0, doc_pkg::OFS_CONTROL, 32'h0, rd, err);
    chk(rd[10:0], 11'h001, "control reset");
    apb(1'b0, doc_pkg::OFS_IRQ_MASK, 32'h0, rd, err);
    chk(rd[10:0], 11'h000, "mask reset");
    apb(1'b1, 8'h40, 32'h1, rd, err);
    chk(11'(err), 11'h001, "unmapped error");
    $display("t_regs done");
  endtask
  task automatic t_pipe();
    for (int i = 0; i < 8; i++) begin
      pulse(1'b1, 1'b1, 11'(i * 83 + 5 + (i == 2) * 1024), 11'(i * 29 + 700 + (i == 5) * 1024));
      chk(seen_a, expw(qa), "bus a word");
      chk(seen_b, expw(qb), "bus b word");
    end
    pulse(1'b1, 1'b0, 11'h155, 11'h000);
    chk(seen_a, expw(qa), "bus a alone");
    chk(seen_b, expw(qb), "bus b untouched");
    $display("t_pipe done");
  endtask
  task automatic t_swap();
    @(posedge clock);
    swap <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk(seen_a, expw(qb), "swapped bus a");
    chk(seen_b, expw(qa), "swapped bus b");
    @(posedge clock);
    swap <= 1'b1;
    $display("t_swap done");
  endtask
  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      @(posedge clock);
      mode <= 2'(m);
      repeat (2) @(posedge clock);
      #1;
      chk(seen_a, expw(qa), "format");
      chk(11'(stab), 11'(m == 1 || m == 2), "stabilizer");
    end
    @(posedge clock);
    mode <= 2'h0;
    $display("t_mode done");
  endtask
  task automatic t_power();
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      {pda, output_enable_n_chan_a} <= 2'(k);
      {pdb, output_enable_n_chan_b} <= 2'(k);
      pulse(1'b1, 1'b0, 11'(k * 97 + 40), 11'h000);
      chk(11'(oe_a), 11'(k != 0), "bus a enable");
      chk(11'(oe_b), 11'(k != 0), "bus b enable");
    end
    @(posedge clock);
    {pda, output_enable_n_chan_a, pdb, output_enable_n_chan_b} <= 4'h0;
    pulse(1'b1, 1'b0, 11'h2aa, 11'h000);
    chk(seen_a, expw(qa), "word after power modes");
    $display("t_power done");
  endtask
  task automatic t_irq();
    apb(1'b1, doc_pkg::OFS_IRQ_STATUS, 32'hf, rd, err);
    apb(1'b1, doc_pkg::OFS_IRQ_MASK, 32'h1, rd, err);
    chk(11'(irq), 11'h000, "irq idle");
    pulse(1'b1, 1'b0, 11'h0f0, 11'h000);
    chk(11'(irq), 11'h001, "irq raised");
    apb(1'b1, doc_pkg::OFS_IRQ_MASK, 32'h0, rd, err);
    @(posedge clock);
    #1;
    chk(11'(irq), 11'h000, "irq masked");
    apb(1'b1, doc_pkg::OFS_IRQ_STATUS, 32'h1, rd, err);
    apb(1'b0, doc_pkg::OFS_IRQ_STATUS, 32'h0, rd, err);
    chk(rd[10:0], 11'h000, "status cleared");
    apb(1'b0, doc_pkg::OFS_COUNT_A, 32'h0, rd, err);
    chk(rd[10:0], 11'(qa.size()), "accepted edges a");
    apb(1'b0, doc_pkg::OFS_COUNT_B, 32'h0, rd, err);
    chk(rd[10:0], 11'(qb.size()), "accepted edges b");
    apb(1'b0, doc_pkg::OFS_LAST_A, 32'h0, rd, err);
    chk(rd[10:0], expw(qa), "snapshot a");
    $display("t_irq done");
  endtask
  // swap pin tied to both sample clocks: bus a carries a while high, b while low
  task automatic t_mux();
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      {sca, scb, swap} <= 3'h7;
      {ra, ca} <= 11'(i * 51 + 300);
      {rb, cb} <= 11'(i * 77 + 90);
      qa.push_back(11'(i * 51 + 300));
      qb.push_back(11'(i * 77 + 90));
      repeat (2) @(posedge clock);
      #1;
      chk(seen_a, expw(qa), "interleave a");
      @(posedge clock);
      {sca, scb, swap} <= 3'h0;
      repeat (2) @(posedge clock);
      #1;
      chk(seen_a, expw(qb), "interleave b");
    end
    @(posedge clock);
    swap <= 1'b1;
    $display("t_mux done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  task automatic finish_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // the whole run needs about 150 cycles; this cuts a hang short
  initial begin
    #50000;
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test();
  end
  // reset, then the scenarios in order
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_pipe();
    t_swap();
    t_mode();
    t_power();
    t_irq();
    t_mux();
    finish_test();
  end
endmodule
